// File: ser_pkg.sv
// Purpose: constants for the status event reporting block
// Assumes: registers are reached by status commands decoded elsewhere into strobes
// Notes: command codes are local numbering of the command strobe port
// How it works
// RULE1: voltage overload raises questionable bit 0 and forces the signal output off.
// RULE2: lost phase lock raises questionable bit 5.
// RULE3: calibration failure, lost memory or unsecured state raises questionable bit 8.
// RULE4: external timebase in use raises questionable bit 9.
// RULE5: unused bits of questionable and standard event registers read as zero.
// RULE6: questionable event bits hold until their query or clear-status.
// RULE7: questionable enable cleared at power-on, by preset, and by writing zero.
// RULE8: enabled questionable event bits summarise into the status byte.
// RULE9: questionable condition is read-only live state; reading clears nothing.
// RULE10: clear-status zeroes all event registers and keeps every enable mask.
// RULE11: operation complete sets standard bit 0 once all work including overlap finished.
// RULE12: query error sets standard bit 2 for its three causes.
// RULE13: device-specific error sets standard bit 3.
// RULE14: execution error sets standard bit 4.
// RULE15: command syntax error sets standard bit 5.
// RULE16: power-up sets standard bit 7 until the register is read or cleared.
// RULE17: standard event query returns contents then clears; clear-status clears too.
// RULE18: standard enable cleared by writing zero, and at power-on only when setting is 1.
// RULE19: status byte query equals serial poll but leaves master summary bit 6.
// RULE20: enabled status bits form bit 6; a rising enabled bit requests service.
// RULE21: service enable survives preset, and power cycles when setting is 0.
// RULE22: enabled standard event bits summarise into the status byte.
// RULE23: questionable summary is status bit 3, standard summary is status bit 5.
// RULE24: event bits latch on condition rise; a set bit ignores further events.
`default_nettype none
package ser_pkg;
  localparam int QW = 16;
  localparam int SW = 8;
  localparam logic [QW-1:0] QUES_USED = 16'h0321;
  localparam logic [SW-1:0] STD_USED = 8'hBD;
  localparam int Q_OVLD = 0;
  localparam int Q_UNLOCK = 5;
  localparam int Q_CAL = 8;
  localparam int Q_EXTREF = 9;
  localparam int S_OPC = 0;
  localparam int S_QERR = 2;
  localparam int S_DEVERR = 3;
  localparam int S_EXEERR = 4;
  localparam int S_CMDERR = 5;
  localparam int S_PWRON = 7;
  localparam int B_ERRQ = 2;
  localparam int B_QUES = 3;
  localparam int B_MAV = 4;
  localparam int B_STD = 5;
  localparam int B_MSS = 6;
  localparam logic [7:0] SRE_USED = 8'hBF;
  localparam logic [QW-1:0] QW_ZERO = 16'h0000;
  localparam logic [SW-1:0] SW_ZERO = 8'h00;
  localparam logic PSC_RESET = 1'b1;
  typedef enum logic [3:0] {
    SER_CMD_NONE      = 4'h0,
    SER_CMD_CLS       = 4'h1,
    SER_CMD_PRESET    = 4'h2,
    SER_CMD_QENAB_WR  = 4'h3,
    SER_CMD_QEVEN_RD  = 4'h4,
    SER_CMD_QCOND_RD  = 4'h5,
    SER_CMD_QENAB_RD  = 4'h6,
    SER_CMD_ESE_WR    = 4'h7,
    SER_CMD_ESE_RD    = 4'h8,
    SER_CMD_ESR_RD    = 4'h9,
    SER_CMD_SRE_WR    = 4'hA,
    SER_CMD_SRE_RD    = 4'hB,
    SER_CMD_STB_RD    = 4'hC,
    SER_CMD_PSC_WR    = 4'hD,
    SER_CMD_PSC_RD    = 4'hE,
    SER_CMD_SPOLL     = 4'hF
  } ser_cmd_t;
  typedef enum logic [1:0] {
    SER_OPC_IDLE = 2'b00,
    SER_OPC_WAIT = 2'b01
  } ser_opc_t;
endpackage
`default_nettype wire

// File: ser_status.sv
// Purpose: status registers, summaries and service request of an instrument
// Assumes: one command strobe per cycle; power-on is i_reset; nonvolatile masks
//   are restored by the caller through i_nv_* at reset release
// Notes: read data appears one cycle after the command, flagged valid for one cycle
`default_nettype none
module ser_status
  import ser_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_cmd_valid,
  input wire ser_pkg::ser_cmd_t i_cmd,
  input wire logic [15:0] i_wdata,
  input wire logic i_volt_overload,
  input wire logic i_pll_unlocked,
  input wire logic i_cal_failed,
  input wire logic i_cal_mem_lost,
  input wire logic i_cal_unsecured,
  input wire logic i_ext_ref_used,
  input wire logic i_opc_pending_done,
  input wire logic i_qerr_empty_read,
  input wire logic i_qerr_unread_query,
  input wire logic i_qerr_buffers_full,
  input wire logic i_device_error,
  input wire logic i_exec_error,
  input wire logic i_syntax_error,
  input wire logic i_error_queue_nonempty,
  input wire logic i_message_available,
  input wire logic [7:0] i_nv_sre,
  input wire logic [7:0] i_nv_ese,
  input wire logic i_nv_psc,
  output logic o_output_disable,
  output logic o_srq,
  output logic [7:0] o_nv_sre,
  output logic o_nv_psc,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data
);
  logic [QW-1:0] qcond;
  logic [QW-1:0] qcond_prev_q;
  logic [QW-1:0] qevent_q, qevent_d;
  logic [QW-1:0] qenable_q;
  logic [SW-1:0] sevent_q, sevent_d;
  logic [SW-1:0] senable_q;
  logic [7:0] sre_q;
  logic psc_q;
  logic rqs_q;
  logic out_dis_q;
  logic load_q;
  ser_opc_t opc_q;
  logic [15:0] rd_q;
  logic rdv_q;
  logic [7:0] stb_prev_q;

  wire logic cmd_cls = i_cmd_valid && i_cmd == SER_CMD_CLS;
  wire logic cmd_pre = i_cmd_valid && i_cmd == SER_CMD_PRESET;
  wire logic cmd_qrd = i_cmd_valid && i_cmd == SER_CMD_QEVEN_RD;
  wire logic cmd_esr = i_cmd_valid && i_cmd == SER_CMD_ESR_RD;
  wire logic cmd_opc_set = i_cmd_valid && i_cmd == SER_CMD_NONE;
  wire logic cmd_poll = i_cmd_valid && i_cmd == SER_CMD_SPOLL;
  wire logic cmd_rd = i_cmd_valid && (i_cmd == SER_CMD_QEVEN_RD || i_cmd == SER_CMD_QCOND_RD
    || i_cmd == SER_CMD_QENAB_RD || i_cmd == SER_CMD_ESE_RD || i_cmd == SER_CMD_ESR_RD
    || i_cmd == SER_CMD_SRE_RD || i_cmd == SER_CMD_STB_RD || i_cmd == SER_CMD_PSC_RD
    || i_cmd == SER_CMD_SPOLL);

  // live condition; unused positions are tied low
  always_comb begin
    qcond = QW_ZERO;
    qcond[Q_OVLD] = i_volt_overload; // RULE1
    qcond[Q_UNLOCK] = i_pll_unlocked; // RULE2
    qcond[Q_CAL] = i_cal_failed | i_cal_mem_lost | i_cal_unsecured; // RULE3
    qcond[Q_EXTREF] = i_ext_ref_used; // RULE4
  end

  // rising condition edges; set wins over a same-cycle clear
  wire logic [QW-1:0] qrise = qcond & ~qcond_prev_q & QUES_USED; // RULE24 RULE5
  always_comb begin
    qevent_d = qevent_q;
    if (cmd_cls || cmd_qrd) begin
      qevent_d = QW_ZERO; // RULE6 RULE10
    end
    qevent_d = qevent_d | qrise; // RULE24
  end

  // operation complete: armed by the command, fires once pending work is done
  wire logic opc_fire = (opc_q == SER_OPC_WAIT) && i_opc_pending_done && !cmd_cls; // RULE11

  logic [SW-1:0] sset;
  always_comb begin
    sset = SW_ZERO;
    sset[S_OPC] = opc_fire; // RULE11
    sset[S_QERR] = i_qerr_empty_read | i_qerr_unread_query | i_qerr_buffers_full; // RULE12
    sset[S_DEVERR] = i_device_error; // RULE13
    sset[S_EXEERR] = i_exec_error; // RULE14
    sset[S_CMDERR] = i_syntax_error; // RULE15
    sset[S_PWRON] = load_q; // RULE16
  end

  always_comb begin
    sevent_d = sevent_q;
    if (cmd_cls || cmd_esr) begin
      sevent_d = SW_ZERO; // RULE17 RULE10
    end
    sevent_d = (sevent_d | sset) & STD_USED; // RULE5
  end

  wire logic ques_sum = |(qevent_q & qenable_q); // RULE8
  wire logic std_sum = |(sevent_q & senable_q); // RULE22
  logic [7:0] stb_base;
  always_comb begin
    stb_base = 8'h00;
    stb_base[B_ERRQ] = i_error_queue_nonempty;
    stb_base[B_QUES] = ques_sum; // RULE23
    stb_base[B_MAV] = i_message_available;
    stb_base[B_STD] = std_sum; // RULE23
  end
  wire logic mss = |(stb_base & sre_q & SRE_USED); // RULE20
  wire logic [7:0] stb_query = stb_base | (8'h01 << B_MSS) & {8{mss}}; // RULE19
  wire logic [7:0] stb_poll = stb_base | (8'h01 << B_MSS) & {8{rqs_q}};
  wire logic [7:0] sel_now = stb_base & sre_q;
  wire logic srq_rise = |(sel_now & ~stb_prev_q); // RULE20

  logic [15:0] rd_mux;
  always_comb begin
    case (i_cmd)
      SER_CMD_QEVEN_RD: rd_mux = qevent_q;
      SER_CMD_QCOND_RD: rd_mux = qcond; // RULE9
      SER_CMD_QENAB_RD: rd_mux = qenable_q;
      SER_CMD_ESE_RD: rd_mux = {8'h00, senable_q};
      SER_CMD_ESR_RD: rd_mux = {8'h00, sevent_q}; // RULE17
      SER_CMD_SRE_RD: rd_mux = {8'h00, sre_q};
      SER_CMD_STB_RD: rd_mux = {8'h00, stb_query}; // RULE19
      SER_CMD_PSC_RD: rd_mux = {15'h0000, psc_q};
      SER_CMD_SPOLL: rd_mux = {8'h00, stb_poll};
      default: rd_mux = 16'h0000;
    endcase
  end

  // read answer is registered: it stands one cycle after the command that asked for it
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      qcond_prev_q <= QW_ZERO;
      qevent_q <= QW_ZERO;
      sevent_q <= SW_ZERO;
      qenable_q <= QW_ZERO; // RULE7
      load_q <= 1'b1;
      rd_q <= 16'h0000;
      rdv_q <= 1'b0;
    end else if (i_ce) begin
      load_q <= 1'b0;
      qcond_prev_q <= qcond;
      qevent_q <= qevent_d;
      sevent_q <= sevent_d;
      if (cmd_pre) begin
        qenable_q <= QW_ZERO; // RULE7
      end else if (i_cmd_valid && i_cmd == SER_CMD_QENAB_WR) begin
        qenable_q <= i_wdata & QUES_USED; // RULE7 RULE5
      end
      rdv_q <= cmd_rd;
      if (cmd_rd) begin
        rd_q <= rd_mux;
      end
    end
  end

  // masks under power-on clear: at release, restored from nonvolatile copy when the setting is 0, zeroed when it is 1
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      senable_q <= SW_ZERO;
      sre_q <= 8'h00;
      psc_q <= PSC_RESET;
    end else if (i_ce) begin
      if (load_q) begin
        psc_q <= i_nv_psc;
        senable_q <= i_nv_psc ? SW_ZERO : i_nv_ese; // RULE18
        sre_q <= i_nv_psc ? 8'h00 : (i_nv_sre & SRE_USED); // RULE21
      end else begin
        if (i_cmd_valid && i_cmd == SER_CMD_ESE_WR) begin
          senable_q <= i_wdata[SW-1:0] & STD_USED; // RULE18
        end
        if (i_cmd_valid && i_cmd == SER_CMD_SRE_WR) begin
          sre_q <= i_wdata[7:0] & SRE_USED; // RULE21
        end
        if (i_cmd_valid && i_cmd == SER_CMD_PSC_WR) begin
          psc_q <= i_wdata[0];
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      opc_q <= SER_OPC_IDLE;
      rqs_q <= 1'b0;
      stb_prev_q <= 8'h00;
      out_dis_q <= 1'b0;
    end else if (i_ce) begin
      stb_prev_q <= sel_now;
      case (opc_q)
        SER_OPC_IDLE: begin
          if (cmd_opc_set) begin
            opc_q <= SER_OPC_WAIT;
          end
        end
        SER_OPC_WAIT: begin
          if (cmd_cls || opc_fire) begin
            opc_q <= SER_OPC_IDLE; // RULE11
          end
        end
        default: opc_q <= SER_OPC_IDLE;
      endcase
      // a fresh rise only: a standing summary must not re-request after a poll
      if (srq_rise) begin
        rqs_q <= 1'b1; // RULE20
      end else if (cmd_poll || !mss) begin
        rqs_q <= 1'b0;
      end
      // output stays off until clear-status, so a brief overload cannot go unnoticed
      if (i_volt_overload) begin
        out_dis_q <= 1'b1; // RULE1
      end else if (i_cmd_valid && i_cmd == SER_CMD_CLS) begin
        out_dis_q <= 1'b0;
      end
    end
  end

  assign o_output_disable = out_dis_q;
  assign o_srq = rqs_q;
  assign o_nv_sre = sre_q;
  assign o_nv_psc = psc_q;
  assign o_rd_valid = rdv_q;
  assign o_rd_data = rd_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_cls_keeps_masks: assert property (i_ce && !load_q && cmd_cls |=> // RULE10
    qenable_q == $past(qenable_q) && senable_q == $past(senable_q))
    else $error("clear-status altered an enable mask");
  a_qevent_clear: assert property (i_ce && cmd_qrd && qrise == QW_ZERO |=> // RULE6
    qevent_q == QW_ZERO) else $error("questionable query did not clear events");
  a_esr_clear: assert property (i_ce && cmd_esr && sset == SW_ZERO |=> // RULE17
    sevent_q == SW_ZERO) else $error("standard query did not clear events");
  a_unused_zero: assert property ((qevent_q & ~QUES_USED) == QW_ZERO // RULE5
    && (sevent_q & ~STD_USED) == SW_ZERO) else $error("unused event bit set");
  a_overload_latch: assert property (i_ce && i_volt_overload // RULE1
    && !qcond_prev_q[Q_OVLD] |=> qevent_q[Q_OVLD] && o_output_disable)
    else $error("overload not reported");
  a_preset_clears: assert property (i_ce && !load_q && cmd_pre |=> qenable_q == QW_ZERO // RULE7
    && sre_q == $past(sre_q)) else $error("preset handled wrongly");
  a_stb_bits: assert property (stb_query[B_QUES] == ques_sum // RULE23
    && stb_query[B_STD] == std_sum) else $error("status byte summary misplaced");
  a_srq_raise: assert property (i_ce && srq_rise |=> o_srq) // RULE20
    else $error("service request not raised");
  a_event_hold: assert property (i_ce && qevent_q[Q_UNLOCK] && !cmd_cls && !cmd_qrd // RULE24
    |=> qevent_q[Q_UNLOCK]) else $error("questionable event dropped");

  // condition rises must reach the event register; a set beats a same-cycle clear
  a_unlock_event: assert property ( // RULE2
    i_ce && i_pll_unlocked && !qcond_prev_q[Q_UNLOCK] |=> qevent_q[Q_UNLOCK])
    else $error("loop unlock event missed");
  a_cal_event: assert property ( // RULE3
    i_ce && (i_cal_failed || i_cal_mem_lost || i_cal_unsecured) && !qcond_prev_q[Q_CAL]
    |=> qevent_q[Q_CAL]) else $error("calibration event missed");
  a_extref_event: assert property ( // RULE4
    i_ce && i_ext_ref_used && !qcond_prev_q[Q_EXTREF] |=> qevent_q[Q_EXTREF])
    else $error("external reference event missed");
  a_qevent_keep: assert property ( // RULE6
    i_ce && !cmd_cls && !cmd_qrd |=> (qevent_q & $past(qevent_q)) == $past(qevent_q))
    else $error("questionable event lost without a clear");
  a_qenab_write: assert property ( // RULE7
    i_ce && i_cmd_valid && i_cmd == SER_CMD_QENAB_WR
    |=> qenable_q == ($past(i_wdata) & QUES_USED)) else $error("enable write lost");
  a_qenab_power: assert property ( // RULE7
    load_q |-> qenable_q == QW_ZERO)
    else $error("questionable enable not zero at power-on");
  a_ques_read: assert property ( // RULE8
    i_ce && i_cmd_valid && i_cmd == SER_CMD_STB_RD |=>
    o_rd_data[B_QUES] == |($past(qevent_q) & $past(qenable_q)))
    else $error("questionable summary wrong in status query");
  a_cond_read: assert property ( // RULE9
    i_ce && i_cmd_valid && i_cmd == SER_CMD_QCOND_RD |=> o_rd_valid && o_rd_data == $past(qcond)
    && (qevent_q & $past(qevent_q)) == $past(qevent_q))
    else $error("condition read wrong or clearing");
  a_cls_clears: assert property ( // RULE10
    i_ce && cmd_cls |=> (qevent_q & ~$past(qrise)) == QW_ZERO
    && (sevent_q & ~$past(sset)) == SW_ZERO) else $error("clear-status left an event");
  // standard event setting: each cause lands in its bit one cycle later; the three query error causes share bit 2
  a_opc_set: assert property ( // RULE11
    i_ce && opc_q == SER_OPC_WAIT && i_opc_pending_done && !cmd_cls |=> sevent_q[S_OPC])
    else $error("operation complete not reported");
  a_opc_idle: assert property ( // RULE11
    i_ce && opc_q == SER_OPC_IDLE && !sevent_q[S_OPC] |=> !sevent_q[S_OPC])
    else $error("operation complete set while not armed");
  a_qerr_event: assert property ( // RULE12
    i_ce && (i_qerr_empty_read || i_qerr_unread_query || i_qerr_buffers_full)
    |=> sevent_q[S_QERR]) else $error("query error not reported");
  a_dev_error: assert property ( // RULE13
    i_ce && i_device_error |=> sevent_q[S_DEVERR])
    else $error("device error not reported");
  a_exec_error: assert property ( // RULE14
    i_ce && i_exec_error |=> sevent_q[S_EXEERR])
    else $error("execution error not reported");
  a_syntax_error: assert property ( // RULE15
    i_ce && i_syntax_error |=> sevent_q[S_CMDERR])
    else $error("command error not reported");
  a_power_flag: assert property ( // RULE16
    i_ce && load_q |=> sevent_q[S_PWRON])
    else $error("power-on flag missing");
  a_power_hold: assert property ( // RULE16
    i_ce && sevent_q[S_PWRON] && !cmd_cls && !cmd_esr |=> sevent_q[S_PWRON])
    else $error("power-on flag dropped early");
  a_sevent_keep: assert property ( // RULE17
    i_ce && !cmd_cls && !cmd_esr |=> (sevent_q & $past(sevent_q)) == $past(sevent_q))
    else $error("standard event lost without a clear");
  // power-on loading of the masks depends on the clearing setting
  a_ese_power: assert property ( // RULE18
    i_ce && load_q |=> senable_q == ($past(i_nv_psc) ? SW_ZERO : $past(i_nv_ese)))
    else $error("standard enable wrong after power-on");
  a_ese_write: assert property ( // RULE18
    i_ce && !load_q && i_cmd_valid && i_cmd == SER_CMD_ESE_WR
    |=> {8'h00, senable_q} == ($past(i_wdata) & {8'h00, STD_USED}))
    else $error("standard enable write lost");
  a_stb_mss: assert property ( // RULE19
    i_ce && i_cmd_valid && i_cmd == SER_CMD_STB_RD |=>
    o_rd_data[B_MSS] == |($past(stb_base) & $past(sre_q)))
    else $error("status query master bit wrong");
  a_sre_power: assert property ( // RULE21
    i_ce && load_q |=> sre_q == ($past(i_nv_psc) ? 8'h00 : $past(i_nv_sre) & SRE_USED))
    else $error("service enable wrong after power-on");
  a_std_read: assert property ( // RULE22
    i_ce && i_cmd_valid && i_cmd == SER_CMD_STB_RD |=>
    o_rd_data[B_STD] == |($past(sevent_q) & $past(senable_q)))
    else $error("standard summary wrong in status query");

  c_srq: cover property (i_ce && srq_rise ##1 o_srq);
  c_opc: cover property (opc_q == SER_OPC_WAIT ##[1:20] sevent_q[S_OPC]);
  c_poll: cover property (o_srq && i_ce && cmd_poll);
  c_esr_clear: cover property (i_ce && cmd_esr && sevent_q != SW_ZERO);
  c_power_keep: cover property (i_ce && load_q && !i_nv_psc);
endmodule
`default_nettype wire

// File: ser_host.sv
// Purpose: remote host model that issues status commands to the status block
// Assumes: a command is taken at the edge after it is raised; read answer one cycle later
// Notes: requests change only just after a rising edge and are held through the taking edge
`default_nettype none
module ser_host
  import ser_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rd_valid,
  input wire logic [15:0] i_rd_data,
  output logic o_cmd_valid,
  output ser_pkg::ser_cmd_t o_cmd,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = SER_CMD_NONE;
    o_wdata = 16'h0000;
  end
  task automatic send(input ser_cmd_t c, input logic [15:0] w);
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    o_cmd <= c;
    o_wdata <= w;
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    // released data shows the inverse so a stale value cannot pass as held
    o_wdata <= ~w;
  endtask
  task automatic rd(input ser_cmd_t c, output logic [15:0] d, output logic v);
    send(c, 16'h0000);
    #1;
    v = i_rd_valid;
    d = i_rd_data;
  endtask
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench for the status event reporting block
// Assumes: host model drives the command port; bench drives condition and event inputs
// Notes: second power-on run covers the clearing setting
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ser_pkg::*;
  logic clk, rst, ce, vo, pll, ext, opcd, eqn, mav, nv_psc, cv, rv, odis, srq, v, nvp;
  logic [7:0] nvs;
  logic [2:0] calx;
  logic [5:0] ex;
  logic [15:0] wd, rdd, d;
  ser_cmd_t cmd;
  int n_mismatch, comparisons;
  ser_status ser_status_inst (.i_clk(clk), .i_reset(rst), .i_ce(ce), .i_cmd_valid(cv),
    .i_cmd(cmd), .i_wdata(wd), .i_volt_overload(vo), .i_pll_unlocked(pll),
    .i_cal_failed(calx[0]), .i_cal_mem_lost(calx[1]), .i_cal_unsecured(calx[2]),
    .i_ext_ref_used(ext), .i_opc_pending_done(opcd), .i_qerr_empty_read(ex[0]),
    .i_qerr_unread_query(ex[1]), .i_qerr_buffers_full(ex[2]), .i_device_error(ex[3]),
    .i_exec_error(ex[4]), .i_syntax_error(ex[5]), .i_error_queue_nonempty(eqn),
    .i_message_available(mav), .i_nv_sre(8'h20), .i_nv_ese(8'h21), .i_nv_psc(nv_psc),
    .o_output_disable(odis), .o_srq(srq), .o_nv_sre(nvs), .o_nv_psc(nvp), .o_rd_valid(rv),
    .o_rd_data(rdd));
  ser_host ser_host_inst (.i_clk(clk), .i_rd_valid(rv), .i_rd_data(rdd), .o_cmd_valid(cv),
    .o_cmd(cmd), .o_wdata(wd));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic stop_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic t_power(input logic psc, input logic [7:0] standard_event_enable);
    @(posedge clk);
    rst <= 1'b1;
    nv_psc <= psc;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    ser_host_inst.rd(SER_CMD_ESR_RD, d, v);
    `CHK("power flag", 16'h0080, d)
    `CHK("read valid", 1'b1, v)
    ser_host_inst.rd(SER_CMD_ESR_RD, d, v);
    `CHK("esr cleared", 16'h0000, d)
    ser_host_inst.rd(SER_CMD_ESE_RD, d, v);
    `CHK("ese power", {8'h00, standard_event_enable}, d)
    ser_host_inst.rd(SER_CMD_SRE_RD, d, v);
    `CHK("sre power", {8'h00, psc ? 8'h00 : 8'h20}, d)
    `CHK("nv sre", psc ? 8'h00 : 8'h20, nvs)
    ser_host_inst.rd(SER_CMD_PSC_RD, d, v);
    `CHK("psc power", {15'h0000, psc}, d)
    `CHK("nv psc", psc, nvp)
    ser_host_inst.rd(SER_CMD_QENAB_RD, d, v);
    `CHK("qenab power", 16'h0000, d)
  endtask
  task automatic t_ques();
    @(posedge clk);
    vo <= 1'b1;
    pll <= 1'b1;
    ext <= 1'b1;
    calx <= 3'b100;
    repeat (2) @(posedge clk);
    ser_host_inst.rd(SER_CMD_QCOND_RD, d, v);
    `CHK("qcond", 16'h0321, d)
    `CHK("out off", 1'b1, odis)
    ser_host_inst.rd(SER_CMD_QCOND_RD, d, v);
    `CHK("qcond again", 16'h0321, d)
    ser_host_inst.rd(SER_CMD_QEVEN_RD, d, v);
    `CHK("qeven", 16'h0321, d)
    ser_host_inst.rd(SER_CMD_QEVEN_RD, d, v);
    `CHK("qeven held", 16'h0000, d)
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      {vo, pll, ext} <= 3'b000;
      calx <= 3'b001 << i;
      ser_host_inst.rd(SER_CMD_QCOND_RD, d, v);
      `CHK("cal cause", 16'h0100, d)
    end
    @(posedge clk);
    calx <= 3'b000;
    // a fresh event, so the clear below has something to remove
    ext <= 1'b1;
    ser_host_inst.send(SER_CMD_CLS, 16'h0000);
    ser_host_inst.rd(SER_CMD_QEVEN_RD, d, v);
    `CHK("qeven cls", 16'h0000, d)
  endtask
  task automatic t_sum();
    ser_host_inst.send(SER_CMD_QENAB_WR, 16'hFFFF);
    ser_host_inst.rd(SER_CMD_QENAB_RD, d, v);
    `CHK("qenab mask", 16'h0321, d)
    ser_host_inst.send(SER_CMD_SRE_WR, 16'h0008);
    @(posedge clk);
    {eqn, mav, pll} <= 3'b111;
    repeat (5) @(posedge clk);
    `CHK("srq", 1'b1, srq)
    ser_host_inst.rd(SER_CMD_STB_RD, d, v);
    `CHK("stb", 16'h005C, d)
    ser_host_inst.rd(SER_CMD_SPOLL, d, v);
    `CHK("poll byte", 16'h005C, d)
    `CHK("poll srq", 1'b0, srq)
    ser_host_inst.rd(SER_CMD_STB_RD, d, v);
    `CHK("stb kept", 16'h005C, d)
    ser_host_inst.send(SER_CMD_PRESET, 16'h0000);
    ser_host_inst.rd(SER_CMD_QENAB_RD, d, v);
    `CHK("preset qenab", 16'h0000, d)
    ser_host_inst.rd(SER_CMD_SRE_RD, d, v);
    `CHK("preset sre", 16'h0008, d)
    @(posedge clk);
    {eqn, mav, pll} <= 3'b000;
  endtask
  task automatic t_std();
    ser_host_inst.send(SER_CMD_CLS, 16'h0000);
    ser_host_inst.send(SER_CMD_ESE_WR, 16'h00FF);
    ser_host_inst.rd(SER_CMD_ESE_RD, d, v);
    `CHK("ese mask", 16'h00BD, d)
    ser_host_inst.send(SER_CMD_NONE, 16'h0000);
    ser_host_inst.rd(SER_CMD_ESR_RD, d, v);
    `CHK("opc waiting", 16'h0000, d)
    @(posedge clk);
    opcd <= 1'b1;
    repeat (2) @(posedge clk);
    ser_host_inst.rd(SER_CMD_ESR_RD, d, v);
    `CHK("opc done", 16'h0001, d)
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      ex <= 6'h01 << i;
      @(posedge clk);
      ex <= 6'h00;
      ser_host_inst.rd(SER_CMD_ESR_RD, d, v);
      `CHK("error bit", (i < 3) ? 16'h0004 : (16'h0001 << i), d)
    end
    @(posedge clk);
    ex <= 6'h08;
    @(posedge clk);
    ex <= 6'h00;
    ser_host_inst.rd(SER_CMD_STB_RD, d, v);
    `CHK("std summary", 16'h0020, d)
    ser_host_inst.send(SER_CMD_CLS, 16'h0000);
    ser_host_inst.rd(SER_CMD_STB_RD, d, v);
    `CHK("stb cls", 16'h0000, d)
    ser_host_inst.rd(SER_CMD_ESE_RD, d, v);
    `CHK("ese kept", 16'h00BD, d)
    @(posedge clk);
    ce <= 1'b0;
    ser_host_inst.send(SER_CMD_ESE_WR, 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    ser_host_inst.rd(SER_CMD_ESE_RD, d, v);
    `CHK("ese frozen", 16'h00BD, d)
    ser_host_inst.send(SER_CMD_ESE_WR, 16'h0000);
    ser_host_inst.rd(SER_CMD_ESE_RD, d, v);
    `CHK("ese zero", 16'h0000, d)
    ser_host_inst.send(SER_CMD_PSC_WR, 16'h0001);
    ser_host_inst.rd(SER_CMD_PSC_RD, d, v);
    `CHK("psc write", 16'h0001, d)
    `CHK("nv psc write", 1'b1, nvp)
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    {rst, ce, vo, pll, ext, opcd, eqn, mav, nv_psc} = 9'h180;
    calx = 3'b000;
    ex = 6'h00;
    n_mismatch = 0;
    comparisons = 0;
    t_power(1'b0, 8'h21);
    t_ques();
    t_sum();
    t_std();
    t_power(1'b1, 8'h00);
    stop_test();
  end
endmodule
`undef CHK
`default_nettype wire
